// ==== inc/lptt_defs.svh ====
/*
 Constants of the low-order path trail termination: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the package and the testbench.
*/
`ifndef LPTT_DEFS_SVH
`define LPTT_DEFS_SVH

`define LPTT_VC12_PAYLOAD 136
`define LPTT_VC11_PAYLOAD 100
`define LPTT_POH_OCTETS 4
`define LPTT_SUBFRAMES 4
`define LPTT_VC12_SUB ((`LPTT_VC12_PAYLOAD + `LPTT_POH_OCTETS) / `LPTT_SUBFRAMES)
`define LPTT_VC11_SUB ((`LPTT_VC11_PAYLOAD + `LPTT_POH_OCTETS) / `LPTT_SUBFRAMES)
`define LPTT_MF_US 500

`define LPTT_SEC_US 1000000
`define LPTT_CLK_MHZ 100
`define LPTT_SEC_CYCLES (`LPTT_SEC_US * `LPTT_CLK_MHZ)

`define LPTT_OFF_CTRL 8'h00
`define LPTT_OFF_TX_TRACE 8'h04
`define LPTT_OFF_EXP_TRACE 8'h08
`define LPTT_OFF_STATUS 8'h0C
`define LPTT_OFF_NEAR_EBC 8'h10
`define LPTT_OFF_NEAR_DS 8'h14
`define LPTT_OFF_FAR_EBC 8'h18
`define LPTT_OFF_FAR_DS 8'h1C
`define LPTT_OFF_RPT_SEQ 8'h20

`define LPTT_CTRL_REPORT 0
`define LPTT_CTRL_BIDIR 1
`define LPTT_CTRL_VC11 2
`define LPTT_CTRL_RST 3'h0
`define LPTT_TRACE_RST 8'h00

`define LPTT_V5_BIP_HI 7
`define LPTT_V5_BIP_LO 6
`define LPTT_V5_REI 5
`define LPTT_V5_LBL_HI 3
`define LPTT_V5_LBL_LO 1
`define LPTT_V5_RDI 0
`define LPTT_LBL_UNEQ 3'h0

`define LPTT_RESP_OKAY 2'h0
`define LPTT_RESP_SLVERR 2'h2

`endif

// ==== inc/lptt_pkg.sv ====
/*
 Types and shared helpers of the low-order path trail termination.
 Assumes lptt_defs.svh is on the include path.
*/
`include "lptt_defs.svh"

package lptt_pkg;

	typedef struct packed {
		logic sof;
		logic [7:0] data;
	} lptt_strm_t;

	typedef enum logic [1:0] {
		LPTT_QUIET = 2'h1,
		LPTT_REPORT = 2'h2
	} lptt_rpt_st_t;

	// Even parity of odd and even bit positions, MSB is bit 1
	function automatic logic [1:0] lptt_fold(input logic [7:0] d);
		return {d[7] ^ d[5] ^ d[3] ^ d[1], d[6] ^ d[4] ^ d[2] ^ d[0]};
	endfunction

	// Path trace sits at the head of the second subframe
	function automatic logic lptt_is_j2(input logic [7:0] idx, input logic vc11);
		return idx == (vc11 ? 8'(`LPTT_VC11_SUB) : 8'(`LPTT_VC12_SUB));
	endfunction

endpackage

// ==== design/lptt_bip2.sv ====
/*
 Running BIP-2 accumulator over one multiframe of a byte stream.
 Assumes sof marks the V5 byte and arrives on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module lptt_bip2 (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Byte stream
	input wire logic valid,
	input wire lptt_pkg::lptt_strm_t strm,
	// Parity of bytes so far, and a first sof byte seen
	output logic [1:0] acc,
	output logic seen
);
	import lptt_pkg::*;

	// At a sof byte, acc still holds the whole previous multiframe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc <= 2'h0;
			seen <= 1'h0;
		end else if (valid) begin
			acc <= strm.sof ? lptt_fold(strm.data) : acc ^ lptt_fold(strm.data);
			if (strm.sof) begin
				seen <= 1'h1;
			end
		end
	end

endmodule

`default_nettype wire

// ==== design/lptt_top.sv ====
/*
 Low-order path trail termination for VC-12 and VC-11 multiframes with
 AXI4-Lite register access and one-second performance counters.
 Assumes both byte streams run on aclk with sof on the V5 byte.
*/
// Functional notes
// - VC-12 multiframe is 136 payload plus 4 overhead
// - VC-11 multiframe is 100 payload plus 4 overhead
// - Insert path trace and V5 bits 1-4, 8; code inserts bits 1-3 and 8, bit 4 passes through
// - Transmit path trace is software provisioned
// - BIP-2 in bits 1-2, REI 3, RDI 8
// - Unidirectional transmit sends REI and RDI zero
// - K4 and N2 pass on without generation
// - Mismatched received trace raises trace defect
// - BIP-2 over previous multiframe checked at V5
// - Any parity difference marks block errored
// - Bidirectional receive extracts REI and RDI
// - Unidirectional receive ignores REI and RDI
// - Label zero raises unequipped defect
// - Errors and defects integrated per second
// - Count near-end errored blocks per second
// - Near defect second on trace or unequipped
// - Count far-end errored blocks per second
// - Far defect second on received RDI
// - Deliver four counts each second when reporting
// - Unidirectional mode produces no far-end counts
// - Receive ignores K4, N2 and V5 bit 4
`timescale 1ns/1ps
`default_nettype none

module lptt_top #(
	parameter int unsigned SEC_CYCLES = `LPTT_SEC_CYCLES,
	parameter int unsigned CNT_W = 16
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Transmit stream
	input wire logic tx_in_valid,
	input wire lptt_pkg::lptt_strm_t tx_in,
	output logic tx_out_valid,
	output lptt_pkg::lptt_strm_t tx_out,
	// Receive stream
	input wire logic rx_valid,
	input wire lptt_pkg::lptt_strm_t rx_in,
	output logic rx_out_valid,
	output lptt_pkg::lptt_strm_t rx_out
);
	import lptt_pkg::*;

	// Ten bits would already overflow at 2000 multiframes a second
	if (CNT_W < 12 || CNT_W > 32 || SEC_CYCLES < 2) begin : g_bad_param
		$error("lptt_top: CNT_W must be 12..32 and SEC_CYCLES at least 2");
	end

	function automatic logic lptt_mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= `LPTT_OFF_RPT_SEQ;
	endfunction

	logic [2:0] ctrl_reg;
	logic [7:0] tx_trace_reg;
	logic [7:0] exp_trace_reg;
	lptt_rpt_st_t state_reg;
	logic report_en;
	logic bidir;
	logic vc11;
	assign report_en = state_reg == LPTT_REPORT;
	assign bidir = ctrl_reg[`LPTT_CTRL_BIDIR];
	assign vc11 = ctrl_reg[`LPTT_CTRL_VC11];

	// Write channel: address and data are held independently
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'h0;
			w_held_reg <= 1'h0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'h1;
				awaddr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'h1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_reg <= 1'h0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= `LPTT_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp <= lptt_mapped(awaddr_reg) ? `LPTT_RESP_OKAY : `LPTT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'h0;
		end
	end

	// Provisioning; only byte lane 0 carries these fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `LPTT_CTRL_RST;
			tx_trace_reg <= `LPTT_TRACE_RST;
			exp_trace_reg <= `LPTT_TRACE_RST;
		end else if (wr_go && wstrb_reg[0]) begin
			case (awaddr_reg)
				`LPTT_OFF_CTRL: ctrl_reg <= wdata_reg[2:0];
				`LPTT_OFF_TX_TRACE: tx_trace_reg <= wdata_reg[7:0];
				`LPTT_OFF_EXP_TRACE: exp_trace_reg <= wdata_reg[7:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= LPTT_QUIET;
		end else begin
			case (ctrl_reg[`LPTT_CTRL_REPORT])
				1'h1: state_reg <= LPTT_REPORT;
				default: state_reg <= LPTT_QUIET;
			endcase
		end
	end

	// Transmit path
	logic [7:0] tx_idx_reg;
	logic [7:0] tx_cur;
	logic [1:0] tx_bip;
	logic tx_is_j2;
	logic rx_blk_err_reg;
	logic tim_reg;
	logic uneq_reg;
	lptt_strm_t tx_next;
	assign tx_cur = tx_in.sof ? 8'h00 : tx_idx_reg;
	assign tx_is_j2 = lptt_is_j2(tx_cur, vc11);

	always_comb begin
		tx_next = tx_in;
		if (tx_in.sof) begin
			tx_next.data[`LPTT_V5_BIP_HI:`LPTT_V5_BIP_LO] = tx_bip;
			tx_next.data[`LPTT_V5_REI] = bidir && rx_blk_err_reg;
			tx_next.data[`LPTT_V5_RDI] = bidir && (tim_reg || uneq_reg);
		end else if (tx_is_j2) begin
			tx_next.data = tx_trace_reg;
		end
	end

	lptt_bip2 u_tx_bip (
		.aclk(aclk),
		.aresetn(aresetn),
		.valid(tx_in_valid),
		.strm(tx_next),
		.acc(tx_bip),
		.seen()
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_idx_reg <= 8'h00;
			tx_out_valid <= 1'h0;
			tx_out <= '0;
		end else begin
			tx_out_valid <= tx_in_valid;
			if (tx_in_valid) begin
				tx_idx_reg <= 8'(tx_cur + 8'h01);
				tx_out <= tx_next;
			end
		end
	end

	// Receive path; only V5 and J2 positions are inspected
	logic [7:0] rx_idx_reg;
	logic [7:0] rx_cur;
	logic [1:0] rx_acc;
	logic rx_seen;
	logic rx_v5;
	logic rx_j2;
	logic rx_bip_err;
	logic rdi_reg;
	logic far_err_evt;
	assign rx_cur = rx_in.sof ? 8'h00 : rx_idx_reg;
	assign rx_v5 = rx_valid && rx_in.sof;
	assign rx_j2 = rx_valid && lptt_is_j2(rx_cur, vc11);
	assign rx_bip_err = rx_v5 && rx_seen &&
		rx_in.data[`LPTT_V5_BIP_HI:`LPTT_V5_BIP_LO] != rx_acc;
	assign far_err_evt = rx_v5 && bidir && rx_in.data[`LPTT_V5_REI];

	lptt_bip2 u_rx_bip (
		.aclk(aclk),
		.aresetn(aresetn),
		.valid(rx_valid),
		.strm(rx_in),
		.acc(rx_acc),
		.seen(rx_seen)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_idx_reg <= 8'h00;
			rx_out_valid <= 1'h0;
			rx_out <= '0;
		end else begin
			rx_out_valid <= rx_valid;
			if (rx_valid) begin
				rx_idx_reg <= 8'(rx_cur + 8'h01);
				rx_out <= rx_in;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tim_reg <= 1'h0;
			uneq_reg <= 1'h0;
			rdi_reg <= 1'h0;
			rx_blk_err_reg <= 1'h0;
		end else begin
			if (rx_j2) begin
				tim_reg <= rx_in.data != exp_trace_reg;
			end
			if (rx_v5) begin
				uneq_reg <= rx_in.data[`LPTT_V5_LBL_HI:`LPTT_V5_LBL_LO] == `LPTT_LBL_UNEQ;
				rdi_reg <= bidir && rx_in.data[`LPTT_V5_RDI];
				rx_blk_err_reg <= rx_bip_err;
			end else if (!bidir) begin
				rdi_reg <= 1'h0;
			end
		end
	end

	// One-second tick shared by every counter
	logic [31:0] sec_cnt_reg;
	logic sec_tick;
	assign sec_tick = sec_cnt_reg == 32'(SEC_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_cnt_reg <= 32'h0;
		end else begin
			sec_cnt_reg <= sec_tick ? 32'h0 : 32'(sec_cnt_reg + 32'h1);
		end
	end

	// An event in the tick cycle belongs to the new second
	logic [CNT_W-1:0] near_cnt_reg;
	logic [CNT_W-1:0] far_cnt_reg;
	logic near_ds_reg;
	logic far_ds_reg;
	logic near_def;
	assign near_def = tim_reg || uneq_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			near_cnt_reg <= '0;
			near_ds_reg <= 1'h0;
		end else if (sec_tick) begin
			near_cnt_reg <= CNT_W'(rx_bip_err);
			near_ds_reg <= near_def;
		end else begin
			near_cnt_reg <= CNT_W'(near_cnt_reg + CNT_W'(rx_bip_err));
			near_ds_reg <= near_ds_reg || near_def;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !bidir) begin
			far_cnt_reg <= '0;
			far_ds_reg <= 1'h0;
		end else if (sec_tick) begin
			far_cnt_reg <= CNT_W'(far_err_evt);
			far_ds_reg <= rdi_reg;
		end else begin
			far_cnt_reg <= CNT_W'(far_cnt_reg + CNT_W'(far_err_evt));
			far_ds_reg <= far_ds_reg || rdi_reg;
		end
	end

	// Reports to the manager; frozen while not reporting
	logic [CNT_W-1:0] rpt_near_cnt_reg;
	logic [CNT_W-1:0] rpt_far_cnt_reg;
	logic rpt_near_ds_reg;
	logic rpt_far_ds_reg;
	logic [15:0] rpt_seq_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rpt_near_cnt_reg <= '0;
			rpt_far_cnt_reg <= '0;
			rpt_near_ds_reg <= 1'h0;
			rpt_far_ds_reg <= 1'h0;
			rpt_seq_reg <= 16'h0;
		end else if (sec_tick && report_en) begin
			rpt_near_cnt_reg <= near_cnt_reg;
			rpt_far_cnt_reg <= far_cnt_reg;
			rpt_near_ds_reg <= near_ds_reg;
			rpt_far_ds_reg <= far_ds_reg;
			rpt_seq_reg <= 16'(rpt_seq_reg + 16'h1);
		end
	end

	// Read channel answers one cycle after the address is taken
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `LPTT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'h1;
			s_axi_rresp <= lptt_mapped(s_axi_araddr) ? `LPTT_RESP_OKAY : `LPTT_RESP_SLVERR;
			case (s_axi_araddr)
				`LPTT_OFF_CTRL: s_axi_rdata <= 32'(ctrl_reg);
				`LPTT_OFF_TX_TRACE: s_axi_rdata <= 32'(tx_trace_reg);
				`LPTT_OFF_EXP_TRACE: s_axi_rdata <= 32'(exp_trace_reg);
				`LPTT_OFF_STATUS: s_axi_rdata <= report_en ?
					32'({rx_blk_err_reg, rdi_reg, uneq_reg, tim_reg}) : 32'h0;
				`LPTT_OFF_NEAR_EBC: s_axi_rdata <= 32'(rpt_near_cnt_reg);
				`LPTT_OFF_NEAR_DS: s_axi_rdata <= 32'(rpt_near_ds_reg);
				`LPTT_OFF_FAR_EBC: s_axi_rdata <= 32'(rpt_far_cnt_reg);
				`LPTT_OFF_FAR_DS: s_axi_rdata <= 32'(rpt_far_ds_reg);
				`LPTT_OFF_RPT_SEQ: s_axi_rdata <= 32'(rpt_seq_reg);
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'h0;
		end
	end

	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_tx_v5;
		tx_in_valid && tx_in.sof;
	endsequence
	sequence s_uni2;
		!bidir ##1 !bidir;
	endsequence

	property p_tx_uni;
		s_tx_v5 ##0 !bidir |=> tx_out_valid && !tx_out.data[`LPTT_V5_REI] && !tx_out.data[`LPTT_V5_RDI];
	endproperty
	a_tx_uni: assert property (p_tx_uni) else $error("REI or RDI sent while unidirectional");

	property p_tx_label;
		s_tx_v5 |=> tx_out.data[3:1] == $past(tx_in.data[3:1]);
	endproperty
	a_tx_label: assert property (p_tx_label) else $error("Signal label altered");

	property p_tx_j2;
		tx_in_valid && !tx_in.sof && tx_is_j2 |=> tx_out.data == $past(tx_trace_reg);
	endproperty
	a_tx_j2: assert property (p_tx_j2) else $error("Path trace not inserted");

	property p_tx_rei;
		s_tx_v5 ##0 (bidir && rx_blk_err_reg) |=> tx_out.data[`LPTT_V5_REI];
	endproperty
	a_tx_rei: assert property (p_tx_rei) else $error("REI not returned after errored block");

	property p_tim;
		rx_j2 && rx_in.data != exp_trace_reg |=> tim_reg;
	endproperty
	a_tim: assert property (p_tim) else $error("Trace mismatch not raised");

	property p_near_cnt;
		rx_bip_err && !sec_tick |=> near_cnt_reg == CNT_W'($past(near_cnt_reg) + 1'h1);
	endproperty
	a_near_cnt: assert property (p_near_cnt) else $error("Errored block not counted");

	property p_far_uni;
		s_uni2 |-> far_cnt_reg == '0 && !far_ds_reg;
	endproperty
	a_far_uni: assert property (p_far_uni) else $error("Far-end counts while unidirectional");

	property p_quiet;
		sec_tick && !report_en |=> $stable(rpt_seq_reg) && $stable(rpt_near_cnt_reg);
	endproperty
	a_quiet: assert property (p_quiet) else $error("Report delivered outside reporting state");

	property p_report;
		sec_tick && report_en |=> rpt_seq_reg == 16'($past(rpt_seq_reg) + 1'h1) &&
			rpt_near_cnt_reg == $past(near_cnt_reg) && rpt_far_cnt_reg == $past(far_cnt_reg);
	endproperty
	a_report: assert property (p_report) else $error("Second report not delivered");

	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("Write response dropped before taken");

endmodule

`default_nettype wire

// ==== testbench/lptt_far.sv ====
/*
 Far-side model: remote path terminator sending receive multiframes.
 Assumes go pulses for one cycle while idle and requests stay steady to the end of the frame.
*/
`timescale 1ns/1ps
`default_nettype none

module lptt_far (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Frame request
	input wire logic go,
	input wire logic vc11,
	input wire logic [7:0] v5,
	input wire logic [7:0] j2,
	input wire logic bad_bip,
	output logic busy,
	// Receive stream into the block
	output logic rx_valid,
	output lptt_pkg::lptt_strm_t rx_in
);
	import lptt_pkg::*;
	logic [7:0] idx, d;
	logic [1:0] acc, prev;

	function automatic logic [1:0] par(input logic [7:0] b);
		return {^(b & 8'hAA), ^(b & 8'h55)};
	endfunction

	// Label bits come from the request untouched; BIP covers the previous frame as sent
	always_comb begin
		if (idx == 8'h00) begin
			d = {prev ^ {2{bad_bip}}, v5[5:0]};
		end else if (idx == (vc11 ? 8'h1A : 8'h23)) begin
			d = j2;
		end else begin
			d = idx * 8'h3B + 8'h11;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			idx <= 8'h00;
			acc <= 2'h0;
			prev <= 2'h0;
			rx_valid <= 1'b0;
			rx_in <= '0;
		end else if (busy) begin
			rx_valid <= 1'b1;
			rx_in <= '{sof: idx == 8'h00, data: d};
			acc <= (idx == 8'h00 ? 2'h0 : acc) ^ par(d);
			idx <= idx + 8'h01;
			if (idx == (vc11 ? 8'h67 : 8'h8B)) begin
				busy <= 1'b0;
				prev <= acc ^ par(d);
			end
		end else begin
			// Released line toggles so a stale byte never looks valid
			rx_valid <= 1'b0;
			rx_in <= '{sof: 1'b0, data: ~rx_in.data};
			idx <= 8'h00;
			busy <= go;
		end
	end
endmodule

`default_nettype wire

// ==== testbench/lptt_top_tb.sv ====
/*
 Self-checking bench: register access, transmit overhead, receive monitoring, one-second reports.
 Assumes lptt_pkg and lptt_far are compiled first; seconds shortened to 2000 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lptt_defs.svh"

module lptt_top_tb;
	import lptt_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_in_valid, tx_out_valid, rx_valid;
	logic rx_out_valid, go, fvc11, fbad, fbusy, rx_v_d;
	logic [7:0] s_axi_awaddr, s_axi_araddr, fv5, fj2;
	logic [31:0] s_axi_wdata, s_axi_rdata, seq;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, tx_par, resp;
	lptt_strm_t tx_in, tx_out, rx_in, rx_out, rx_d;
	logic [7:0] cap [0:255];
	int cidx, n_mismatch, num_checks;

	lptt_top #(.SEC_CYCLES(2000), .CNT_W(16)) lptt_top_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.tx_in_valid(tx_in_valid), .tx_in(tx_in), .tx_out_valid(tx_out_valid), .tx_out(tx_out),
		.rx_valid(rx_valid), .rx_in(rx_in), .rx_out_valid(rx_out_valid), .rx_out(rx_out)
	);

	lptt_far lptt_far_inst (
		.aclk(aclk), .aresetn(aresetn), .go(go), .vc11(fvc11), .v5(fv5), .j2(fj2),
		.bad_bip(fbad), .busy(fbusy), .rx_valid(rx_valid), .rx_in(rx_in)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Transmit capture, indexed from the start-of-multiframe byte
	always @(posedge aclk) begin
		if (tx_out_valid === 1'b1) begin
			cidx = tx_out.sof ? 0 : cidx + 1;
			cap[cidx[7:0]] = tx_out.data;
		end
	end

	// Receive bytes leave one cycle late and unchanged, overhead included
	always @(posedge aclk) begin
		if (aresetn === 1'b1 && rx_v_d === 1'b1) begin
			chk_val({22'h0, rx_out_valid, rx_out}, {22'h0, 1'b1, rx_d}, "receive passthrough");
		end
		rx_v_d <= rx_valid;
		rx_d <= rx_in;
	end

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 8'h1D + 8'h07);
	endfunction

	task automatic chk_val(input logic [31:0] g, input logic [31:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic chk_resp(input logic [1:0] g, input logic [1:0] e, input string m);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t %s response %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `LPTT_RESP_OKAY);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		chk_resp(s_axi_bresp, er, "write");
		s_axi_bready <= 1'b0;
	endtask

	task automatic rdq(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		q = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `LPTT_RESP_OKAY);
		logic [31:0] q;
		logic [1:0] r;
		rdq(a, q, r);
		chk_val(q, e, "read data");
		chk_resp(r, er, "read");
	endtask

	// Polls the report sequence until one second closes
	task automatic sync_sec();
		logic [31:0] s0, s1;
		logic [1:0] r;
		rdq(`LPTT_OFF_RPT_SEQ, s0, r);
		s1 = s0;
		while (s1 === s0) rdq(`LPTT_OFF_RPT_SEQ, s1, r);
		chk_val(s1, s0 + 32'h1, "report sequence");
	endtask

	task automatic tx_frame(input logic v11, input logic rei, input logic rdi);
		int len, j;
		logic [1:0] p;
		logic [7:0] e;
		len = v11 ? 104 : 140;
		j = v11 ? 26 : 35;
		for (int i = 0; i < len; i++) begin
			@(posedge aclk);
			tx_in_valid <= 1'b1;
			tx_in <= '{sof: i == 0, data: i == 0 ? 8'hF3 : pat(i)};
		end
		@(posedge aclk);
		tx_in_valid <= 1'b0;
		repeat (2) @(posedge aclk);
		p = 2'h0;
		for (int i = 0; i < len; i++) begin
			e = i == 0 ? {tx_par, rei, 4'h9, rdi} : i == j ? 8'hA5 : pat(i);
			chk_val({24'h0, cap[i]}, {24'h0, e}, "transmit byte");
			p = p ^ {^(e & 8'hAA), ^(e & 8'h55)};
		end
		tx_par = p;
	endtask

	task automatic rx_frame(input logic [7:0] v, input logic [7:0] j, input logic bad);
		@(posedge aclk);
		fv5 <= v;
		fj2 <= j;
		fbad <= bad;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		while (fbusy === 1'b1) @(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Whole run needs about 10500 cycles
	initial begin
		#600000;
		n_mismatch++;
		$display("ERROR %0t watchdog expired", $time);
		complete_run();
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_in_valid, tx_in, go, fvc11, fv5, fj2, fbad} = '0;
		s_axi_wstrb = 4'hF;
		{tx_par, cidx, n_mismatch, num_checks} = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0);
		rd(8'h24, 32'h0, `LPTT_RESP_SLVERR);
		rd(8'h02, 32'h0, `LPTT_RESP_SLVERR);
		wr(8'h24, 32'h1, `LPTT_RESP_SLVERR);
		wr(`LPTT_OFF_NEAR_EBC, 32'h5);
		rd(`LPTT_OFF_NEAR_EBC, 32'h0);
		wr(`LPTT_OFF_TX_TRACE, 32'hA5);
		rd(`LPTT_OFF_TX_TRACE, 32'hA5);
		s_axi_wstrb <= 4'hE;
		wr(`LPTT_OFF_TX_TRACE, 32'h5A);
		s_axi_wstrb <= 4'hF;
		rd(`LPTT_OFF_TX_TRACE, 32'hA5);
		$display("test map done");
		for (int m = 0; m < 2; m++) begin
			wr(`LPTT_OFF_CTRL, {29'h0, m[0], 2'h0});
			tx_frame(m[0], 1'b0, 1'b0);
			tx_frame(m[0], 1'b0, 1'b0);
		end
		$display("test transmit done");
		wr(`LPTT_OFF_EXP_TRACE, 32'h3C);
		wr(`LPTT_OFF_CTRL, 32'h3);
		sync_sec();
		rx_frame(8'h02, 8'h3C, 1'b0);
		rx_frame(8'h02, 8'h3C, 1'b1);
		rd(`LPTT_OFF_STATUS, 32'h8);
		tx_frame(1'b0, 1'b1, 1'b0);
		rx_frame(8'h22, 8'h3C, 1'b0);
		rx_frame(8'h03, 8'h77, 1'b0);
		rd(`LPTT_OFF_STATUS, 32'h5);
		tx_frame(1'b0, 1'b0, 1'b1);
		rx_frame(8'h12, 8'h3C, 1'b0);
		rd(`LPTT_OFF_STATUS, 32'h0);
		sync_sec();
		rd(`LPTT_OFF_NEAR_EBC, 32'h1);
		rd(`LPTT_OFF_NEAR_DS, 32'h1);
		rd(`LPTT_OFF_FAR_EBC, 32'h1);
		rd(`LPTT_OFF_FAR_DS, 32'h1);
		$display("test two-way done");
		wr(`LPTT_OFF_CTRL, 32'h1);
		sync_sec();
		rx_frame(8'h21, 8'h3C, 1'b1);
		rd(`LPTT_OFF_STATUS, 32'hA);
		tx_frame(1'b0, 1'b0, 1'b0);
		sync_sec();
		rd(`LPTT_OFF_NEAR_EBC, 32'h1);
		rd(`LPTT_OFF_NEAR_DS, 32'h1);
		rd(`LPTT_OFF_FAR_EBC, 32'h0);
		rd(`LPTT_OFF_FAR_DS, 32'h0);
		$display("test one-way done");
		wr(`LPTT_OFF_CTRL, 32'h5);
		fvc11 <= 1'b1;
		rx_frame(8'h02, 8'h3C, 1'b0);
		rd(`LPTT_OFF_STATUS, 32'h0);
		rx_frame(8'h02, 8'h55, 1'b0);
		rd(`LPTT_OFF_STATUS, 32'h1);
		wr(`LPTT_OFF_CTRL, 32'h4);
		rd(`LPTT_OFF_STATUS, 32'h0);
		rdq(`LPTT_OFF_RPT_SEQ, seq, resp);
		repeat (2100) @(posedge aclk);
		rd(`LPTT_OFF_RPT_SEQ, seq);
		$display("test quiet done");
		complete_run();
	end
endmodule

`default_nettype wire
